// [serial_ctrl.sv]
// Module: asynchronous serial transceiver with control registers on APB
//
// Contract
// - Nine-bit mode stores received ninth bit
// - Nine-bit mode sends stored ninth bit
// - Low-power disable stops after current byte
// - Length bit picks eight or nine data
// - Wake bit picks idle or address wakeup
// - Parity sits at MSB, checked on receive
// - Parity enable changes after current byte
// - Parity odd select, applied after byte
// - Parity error raises interrupt when enabled
// - Empty buffer interrupt when enabled
// - Transmit done interrupt when enabled
// - Overrun or full interrupt when enabled
// - Idle line interrupt when enabled
// - Enable toggle during a frame sends idle preamble
// - One bit time before transmit starts
// - Pin released when both disabled and no frame is sending, or low-power halted
// - Receiver enable starts start-bit search
// - Mute bit, cleared by hardware wakeup
// - Break sent while set, one more after
// - Empty flag set on shift load
// - Full flag on word, overrun if full
`timescale 1ns/1ps
module serial_ctrl (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rxd,
   output logic             txd_o,
   output logic             txd_oe,
   output logic             irq
);
   // ************************************************************
   // Reset and input synchronisers
   // ************************************************************
   logic       rst_s1, rstn;
   logic       rx_s1, rx_s2;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1 <= 1'b0;
         rstn   <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rstn   <= rst_s1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else begin
         rx_s1 <= rxd;
         rx_s2 <= rx_s1;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]  frame_reg, enable_reg, status_reg, rxdata_reg, txhold_reg;
   logic [15:0] baud_reg;
   logic        status_seen_reg;
   logic        acc, wr, rd;
   logic        tx_load, tx_end, tx_data_end, rx_word, rx_perr, rx_ferr, rx_idle, wake_hit;
   logic        rx_b8;
   logic [7:0]  rx_b;
   assign acc = psel && penable;
   assign wr  = acc && pwrite;
   assign rd  = acc && !pwrite;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frame_reg <= serial_pkg::FRAME_RST;
      end else begin
         if (wr && paddr == serial_pkg::OFF_FRAME)
            frame_reg[serial_pkg::F_TX9:0] <= pwdata[serial_pkg::F_TX9:0];
         if (rx_word && frame_reg[serial_pkg::F_LEN9])
            frame_reg[serial_pkg::F_RX9] <= rx_b8;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enable_reg <= serial_pkg::ENABLE_RST;
      end else if (wr && paddr == serial_pkg::OFF_ENABLE) begin
         enable_reg <= pwdata[7:0];
      end else if (wake_hit) begin
         enable_reg[serial_pkg::E_MUTE] <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         baud_reg <= serial_pkg::BAUD_RST;
      end else if (wr && paddr == serial_pkg::OFF_BAUD) begin
         baud_reg <= pwdata[15:0];
      end
   end

   // Clear sequence: a status access arms, then a data access clears
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_seen_reg <= 1'b0;
      end else if (acc) begin
         status_seen_reg <= (paddr == serial_pkg::OFF_STATUS);
      end
   end

   logic clr_tx, clr_rx;
   assign clr_tx = wr && paddr == serial_pkg::OFF_DATA && status_seen_reg;
   assign clr_rx = rd && paddr == serial_pkg::OFF_DATA && status_seen_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txhold_reg <= 8'h00;
      end else if (wr && paddr == serial_pkg::OFF_DATA) begin
         txhold_reg <= pwdata[7:0];
      end
   end

   // Set wins over clear for every flag
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_reg <= serial_pkg::STATUS_RST;
      end else begin
         if (tx_load)
            status_reg[serial_pkg::S_TXE] <= 1'b1;
         else if (clr_tx)
            status_reg[serial_pkg::S_TXE] <= 1'b0;
         if (tx_data_end)
            status_reg[serial_pkg::S_TC] <= 1'b1;
         else if (clr_tx)
            status_reg[serial_pkg::S_TC] <= 1'b0;
         if (rx_word)
            status_reg[serial_pkg::S_RXF] <= 1'b1;
         else if (clr_rx)
            status_reg[serial_pkg::S_RXF] <= 1'b0;
         if (rx_word && status_reg[serial_pkg::S_RXF])
            status_reg[serial_pkg::S_OVR] <= 1'b1;
         else if (clr_rx)
            status_reg[serial_pkg::S_OVR] <= 1'b0;
         if (rx_idle)
            status_reg[serial_pkg::S_IDLE] <= 1'b1;
         else if (clr_rx)
            status_reg[serial_pkg::S_IDLE] <= 1'b0;
         if (rx_word && !status_reg[serial_pkg::S_RXF] && rx_ferr)
            status_reg[serial_pkg::S_FE] <= 1'b1;
         else if (clr_rx)
            status_reg[serial_pkg::S_FE] <= 1'b0;
         if (rx_word && rx_perr)
            status_reg[serial_pkg::S_PE] <= 1'b1;
         else if (clr_rx || clr_tx)
            status_reg[serial_pkg::S_PE] <= 1'b0;
      end
   end

   // Overrun keeps the old data word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rxdata_reg <= 8'h00;
      end else if (rx_word && !status_reg[serial_pkg::S_RXF]) begin
         rxdata_reg <= rx_b;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               serial_pkg::OFF_STATUS: prdata <= {24'h00_0000, status_reg};
               serial_pkg::OFF_DATA:   prdata <= {24'h00_0000, rxdata_reg};
               serial_pkg::OFF_FRAME:  prdata <= {24'h00_0000, frame_reg};
               serial_pkg::OFF_ENABLE: prdata <= {24'h00_0000, enable_reg};
               serial_pkg::OFF_BAUD:   prdata <= {16'h0000, baud_reg};
               default:                prdata <= 32'h0000_0000;
            endcase
         end
         if (psel && !penable)
            pslverr <= !(paddr == serial_pkg::OFF_STATUS || paddr == serial_pkg::OFF_DATA ||
                         paddr == serial_pkg::OFF_FRAME || paddr == serial_pkg::OFF_ENABLE ||
                         paddr == serial_pkg::OFF_BAUD);
      end
   end

   // ************************************************************
   // Oversampling tick, sixteen per bit
   // ************************************************************
   logic [15:0] div_reg;
   logic        tick;
   logic        halted;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 16'h0000;
         tick    <= 1'b0;
      end else if (halted) begin
         div_reg <= 16'h0000;
         tick    <= 1'b0;
      end else if (div_reg >= baud_reg - 16'h0001) begin
         div_reg <= 16'h0000;
         tick    <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick    <= 1'b0;
      end
   end

   // ************************************************************
   // Transmitter
   // ************************************************************
   typedef enum logic [3:0] {
      TX_IDLE = 4'b0001,
      TX_WAIT = 4'b0010,
      TX_SEND = 4'b0100,
      TX_PAD  = 4'b1000
   } tx_state_t;
   tx_state_t  tx_state_reg;
   logic [10:0] tx_sh_reg;
   logic [3:0]  tx_bits_reg, tx_sub_reg;
   logic        tx_is_data_reg, te_prev_reg, te_pulse_reg, brk_pend_reg, tx_used_reg;
   logic        tx_len9_reg, tx_busy;
   logic        tx_par, rx_idle_st;
   assign tx_busy = tx_state_reg != TX_IDLE;
   assign halted  = frame_reg[serial_pkg::F_LPD] && !tx_busy && rx_idle_st;
   assign tx_load = tx_state_reg == TX_IDLE && enable_reg[serial_pkg::E_TE] && !te_pulse_reg
                    && !brk_pend_reg && !enable_reg[serial_pkg::E_BRK] && te_prev_reg
                    && !status_reg[serial_pkg::S_TXE] && !halted && tick;
   // Parity taken at load so a mid-byte change waits for the next word
   assign tx_par = frame_reg[serial_pkg::F_PODD] ^ (frame_reg[serial_pkg::F_LEN9] ?
                   ^txhold_reg : ^txhold_reg[6:0]);
   assign tx_end = tx_state_reg == TX_SEND && tick && tx_sub_reg == serial_pkg::OVS
                   && tx_bits_reg == 4'h0;
   assign tx_data_end = tx_end && tx_is_data_reg;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         te_prev_reg  <= 1'b0;
         te_pulse_reg <= 1'b0;
         brk_pend_reg <= 1'b0;
         tx_used_reg  <= 1'b0;
      end else begin
         te_prev_reg <= enable_reg[serial_pkg::E_TE];
         if (enable_reg[serial_pkg::E_TE])
            tx_used_reg <= 1'b1;
         if (tx_busy && !te_prev_reg && enable_reg[serial_pkg::E_TE])
            te_pulse_reg <= 1'b1;
         else if (tx_state_reg == TX_IDLE && te_pulse_reg && tick)
            te_pulse_reg <= 1'b0;
         if (enable_reg[serial_pkg::E_BRK])
            brk_pend_reg <= 1'b1;
         else if (tx_state_reg == TX_IDLE && brk_pend_reg && tick)
            brk_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_state_reg   <= TX_IDLE;
         tx_sh_reg      <= 11'h7FF;
         tx_bits_reg    <= 4'h0;
         tx_sub_reg     <= 4'h0;
         tx_is_data_reg <= 1'b0;
         tx_len9_reg    <= 1'b0;
      end else if (!enable_reg[serial_pkg::E_TE] && !tx_busy) begin
         tx_state_reg <= TX_IDLE;
      end else begin
         unique case (tx_state_reg)
            TX_IDLE: begin
               if (!te_prev_reg && enable_reg[serial_pkg::E_TE]) begin
                  tx_state_reg <= TX_WAIT;
                  tx_sub_reg   <= 4'h0;
               end else if (tick && (te_pulse_reg || brk_pend_reg ||
                                     enable_reg[serial_pkg::E_BRK])) begin
                  // Idle preamble is all ones, break is all zeros
                  tx_sh_reg      <= te_pulse_reg ? 11'h7FF : 11'h000;
                  tx_bits_reg    <= frame_reg[serial_pkg::F_LEN9] ? 4'hA : 4'h9;
                  tx_sub_reg     <= 4'h0;
                  tx_is_data_reg <= 1'b0;
                  tx_state_reg   <= TX_SEND;
               end else if (tx_load) begin
                  tx_len9_reg <= frame_reg[serial_pkg::F_LEN9];
                  if (frame_reg[serial_pkg::F_LEN9]) begin
                     tx_sh_reg <= {1'b1,
                        frame_reg[serial_pkg::F_PEN] ? tx_par : frame_reg[serial_pkg::F_TX9],
                        txhold_reg, 1'b0};
                     tx_bits_reg <= 4'hA;
                  end else begin
                     tx_sh_reg <= {2'b11,
                        frame_reg[serial_pkg::F_PEN] ? tx_par : txhold_reg[7],
                        txhold_reg[6:0], 1'b0};
                     tx_bits_reg <= 4'h9;
                  end
                  tx_sub_reg     <= 4'h0;
                  tx_is_data_reg <= 1'b1;
                  tx_state_reg   <= TX_SEND;
               end
            end
            TX_WAIT: if (tick) begin
               tx_sub_reg <= tx_sub_reg + 4'h1;
               if (tx_sub_reg == serial_pkg::OVS)
                  tx_state_reg <= TX_IDLE;
            end
            TX_SEND: if (tick) begin
               tx_sub_reg <= tx_sub_reg + 4'h1;
               if (tx_sub_reg == serial_pkg::OVS) begin
                  tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
                  if (tx_bits_reg == 4'h0)
                     tx_state_reg <= TX_IDLE;
                  else
                     tx_bits_reg <= tx_bits_reg - 4'h1;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         txd_o  <= 1'b1;
         txd_oe <= 1'b0;
      end else begin
         txd_o  <= (tx_state_reg == TX_SEND) ? tx_sh_reg[0] : 1'b1;
         // Pin stays owned once used, until both directions are off and no frame is sending, or low-power halts
         txd_oe <= !halted && tx_used_reg && (enable_reg[serial_pkg::E_TE] ||
                   enable_reg[serial_pkg::E_RE] || tx_busy);
      end
   end

   // ************************************************************
   // Receiver
   // ************************************************************
   logic [9:0] rx_sh_reg;
   logic [3:0] rx_bits_reg, rx_sub_reg, quiet_reg;
   logic       rx_act_reg, rx_len9_reg, rx_pen_reg, rx_podd_reg, rx_seen_reg;
   logic       rx_par_calc;
   assign rx_idle_st = !rx_act_reg;
   assign rx_b8 = rx_sh_reg[9];
   assign rx_b  = rx_sh_reg[8:1];
   assign rx_par_calc = rx_podd_reg ^ (rx_len9_reg ? ^rx_sh_reg[9:1] : ^rx_sh_reg[8:1]);
   logic rx_done, rx_addr_mark;
   assign rx_done = rx_act_reg && tick && rx_sub_reg == serial_pkg::OVS_MID
                    && rx_bits_reg == 4'h0;
   assign rx_addr_mark = rx_len9_reg ? rx_sh_reg[9] : rx_sh_reg[8];
   assign rx_ferr = !rx_s2;
   assign rx_perr = rx_pen_reg && rx_par_calc;
   // Muted words are dropped; in address wake mode an address mark word wakes and is kept
   assign rx_word = rx_done && (!enable_reg[serial_pkg::E_MUTE] ||
                    (frame_reg[serial_pkg::F_WAKE] && rx_addr_mark));
   assign wake_hit = enable_reg[serial_pkg::E_MUTE] && (frame_reg[serial_pkg::F_WAKE] ?
                     (rx_done && rx_addr_mark) : rx_idle && rx_seen_reg);
   assign rx_idle = !rx_act_reg && tick && quiet_reg == serial_pkg::OVS && rx_s2 &&
                    rx_sub_reg == serial_pkg::OVS && rx_bits_reg == 4'h1;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_act_reg  <= 1'b0;
         rx_sh_reg   <= 10'h000;
         rx_bits_reg <= 4'h0;
         rx_sub_reg  <= 4'h0;
         quiet_reg   <= 4'h0;
         rx_len9_reg <= 1'b0;
         rx_pen_reg  <= 1'b0;
         rx_podd_reg <= 1'b0;
         rx_seen_reg <= 1'b0;
      end else if (!enable_reg[serial_pkg::E_RE]) begin
         rx_act_reg <= 1'b0;
         rx_bits_reg <= 4'h0;
      end else if (tick) begin
         if (!rx_act_reg) begin
            if (!rx_s2) begin
               // Start bit found; frame format latched for this word
               rx_act_reg  <= 1'b1;
               rx_sub_reg  <= 4'h0;
               rx_bits_reg <= frame_reg[serial_pkg::F_LEN9] ? 4'hA : 4'h9;
               rx_len9_reg <= frame_reg[serial_pkg::F_LEN9];
               rx_pen_reg  <= frame_reg[serial_pkg::F_PEN];
               rx_podd_reg <= frame_reg[serial_pkg::F_PODD];
               quiet_reg   <= 4'h0;
            end else begin
               // Idle after sixteen quiet bit times counted from the stop bit, flagged once per gap
               rx_sub_reg <= rx_sub_reg + 4'h1;
               if (rx_sub_reg == serial_pkg::OVS && quiet_reg != serial_pkg::OVS)
                  quiet_reg <= quiet_reg + 4'h1;
               if (rx_idle)
                  rx_bits_reg <= 4'h0;
            end
         end else begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
            if (rx_sub_reg == serial_pkg::OVS_MID) begin
               if (rx_bits_reg == 4'h0) begin
                  rx_act_reg  <= 1'b0;
                  rx_seen_reg <= 1'b1;
                  rx_bits_reg <= 4'h1;
               end else begin
                  rx_sh_reg   <= rx_len9_reg ? {rx_s2, rx_sh_reg[9:1]}
                                             : {1'b0, rx_s2, rx_sh_reg[8:1]};
                  rx_bits_reg <= rx_bits_reg - 4'h1;
               end
            end
         end
      end
   end

   // ************************************************************
   // Combined interrupt request
   // ************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= (frame_reg[serial_pkg::F_PIE] && status_reg[serial_pkg::S_PE])
              || (enable_reg[serial_pkg::E_TIE] && status_reg[serial_pkg::S_TXE])
              || (enable_reg[serial_pkg::E_TX_DONE_IRQ_ENABLE] && status_reg[serial_pkg::S_TC])
              || (enable_reg[serial_pkg::E_RIE] && (status_reg[serial_pkg::S_OVR]
                  || status_reg[serial_pkg::S_RXF]))
              || (enable_reg[serial_pkg::E_LINE_QUIET_IRQ_ENABLE] && status_reg[serial_pkg::S_IDLE]);
      end
   end
endmodule

// [serial_pkg.sv]
// Package: register map, field positions and timing constants of the serial block
package serial_pkg;
   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_DATA   = 8'h04;
   localparam logic [7:0] OFF_FRAME  = 8'h08;
   localparam logic [7:0] OFF_ENABLE = 8'h0C;
   localparam logic [7:0] OFF_BAUD   = 8'h10;
   // ************************************************************
   // Frame control fields
   // ************************************************************
   localparam int F_RX9   = 7;
   localparam int F_TX9   = 6;
   localparam int F_LPD   = 5;
   localparam int F_LEN9  = 4;
   localparam int F_WAKE  = 3;
   localparam int F_PEN   = 2;
   localparam int F_PODD  = 1;
   localparam int F_PIE   = 0;
   // ************************************************************
   // Enable control fields
   // ************************************************************
   localparam int E_TIE   = 7;
   localparam int E_TX_DONE_IRQ_ENABLE  = 6;
   localparam int E_RIE   = 5;
   localparam int E_LINE_QUIET_IRQ_ENABLE  = 4;
   localparam int E_TE    = 3;
   localparam int E_RE    = 2;
   localparam int E_MUTE  = 1;
   localparam int E_BRK   = 0;
   // ************************************************************
   // Status fields
   // ************************************************************
   localparam int S_TXE   = 7;
   localparam int S_TC    = 6;
   localparam int S_RXF   = 5;
   localparam int S_IDLE  = 4;
   localparam int S_OVR   = 3;
   localparam int S_FE    = 1;
   localparam int S_PE    = 0;
   // ************************************************************
   // Reset values and timing
   // ************************************************************
   localparam logic [7:0]  FRAME_RST  = 8'h00;
   localparam logic [7:0]  ENABLE_RST = 8'h00;
   localparam logic [7:0]  STATUS_RST = 8'hC0;
   localparam logic [15:0] BAUD_RST   = 16'h0010;
   localparam logic [3:0]  OVS        = 4'hF;
   localparam logic [3:0]  OVS_MID    = 4'h7;
endpackage

// [serial_ctrl_chk.sv]
// Checker: bus and control assertions on the serial block ports
`timescale 1ns/1ps
module serial_ctrl_chk (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxd,
   input wire logic        txd_o,
   input wire logic        txd_oe,
   input wire logic        irq
);
   // ************************************************************
   // Shadow copies of the control registers
   // ************************************************************
   logic [7:0] fr_reg;
   logic [7:0] en_reg;
   logic       wr_acc;
   logic       st_rd;
   assign wr_acc = psel && penable && pready && pwrite;
   assign st_rd  = pready && !pwrite && paddr == serial_pkg::OFF_STATUS;
   // Hardware changes only the mute bit and the received ninth bit, which no assertion uses
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) en_reg <= 8'h00;
      else if (wr_acc && paddr == serial_pkg::OFF_ENABLE) en_reg <= pwdata[7:0];
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) fr_reg <= 8'h00;
      else if (wr_acc && paddr == serial_pkg::OFF_FRAME) fr_reg <= pwdata[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   AST_READY_NEXT: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   AST_READY_ONE: assert property (pready |=> !pready) else $error("ready too long");
   AST_READY_ACC: assert property (pready |-> psel && penable) else $error("stray ready");
   AST_ERR_READY: assert property (pslverr |-> pready) else $error("stray slave error");
   AST_BAD_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   AST_TE_DELAY: assert property ($rose(en_reg[serial_pkg::E_TE]) |-> txd_o [*8])
      else $error("transmit began without delay");
   AST_PIN_OWNED: assert property (
      (en_reg[serial_pkg::E_TE] && !fr_reg[serial_pkg::F_LPD]) [*3] |-> txd_oe)
      else $error("pin released while enabled");
   AST_IRQ_MASKED: assert property (
      (en_reg[7:4] == 4'h0 && !fr_reg[serial_pkg::F_PIE]) [*3] |-> !irq)
      else $error("irq with all sources masked");
   AST_IRQ_TXE: assert property (st_rd && prdata[serial_pkg::S_TXE]
      && en_reg[serial_pkg::E_TIE] |-> ##[0:2] irq) else $error("no irq on empty");
   AST_IRQ_RXF: assert property (st_rd && prdata[serial_pkg::S_RXF]
      && en_reg[serial_pkg::E_RIE] |-> ##[0:2] irq) else $error("no irq on full");
   cover property (pslverr);
   cover property (irq);
   cover property (txd_oe && !txd_o);
endmodule
bind serial_ctrl serial_ctrl_chk serial_ctrl_chk_inst (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_o(txd_o),
   .txd_oe(txd_oe), .irq(irq));

// [serial_peer.sv]
// Remote serial transceiver model: frame receiver and sender
`timescale 1ns/1ps
module serial_peer #(
   parameter int BT = 64
) (
   input  wire logic       clk,
   input  wire logic       txd_o,
   input  wire logic       txd_oe,
   input  wire logic       nine,
   output logic            rxd,
   output logic [8:0]      got,
   output int              got_cnt
);
   // Pull-up holds the line high while the block has released it
   wire        line = txd_oe ? txd_o : 1'b1;
   logic [8:0] w;
   initial begin
      rxd = 1'b1;
      got = 9'h000;
      got_cnt = 0;
      forever begin
         @(negedge line);
         repeat (BT / 2) @(posedge clk);
         w = 9'h000;
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BT) @(posedge clk);
            w[i] = line;
         end
         repeat (BT) @(posedge clk);
         got = w;
         got_cnt++;
      end
   end
   // Length is chosen per call and never changes within a frame
   task automatic send(input logic [8:0] v, input int n);
      @(posedge clk);
      rxd <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (BT) @(posedge clk);
         rxd <= v[i];
      end
      repeat (BT) @(posedge clk);
      rxd <= 1'b1;
      repeat (BT + 4) @(posedge clk);
   endtask
endmodule

// [testbench.sv]
// Testbench: register access, transmit, receive, interrupt and break tests
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] ST = serial_pkg::OFF_STATUS;
   localparam logic [7:0] DT = serial_pkg::OFF_DATA;
   localparam logic [7:0] FR = serial_pkg::OFF_FRAME;
   localparam logic [7:0] EN = serial_pkg::OFF_ENABLE;
   logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
   logic        rxd, txd_o, txd_oe, irq, nine, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic [8:0]  got;
   int          got_cnt, errors, cmp_count;
   serial_ctrl serial_ctrl_inst (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd_o(txd_o), .txd_oe(txd_oe), .irq(irq));
   serial_peer #(.BT(64)) serial_peer_inst (.clk(clk), .txd_o(txd_o), .txd_oe(txd_oe),
      .nine(nine), .rxd(rxd), .got(got), .got_cnt(got_cnt));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic finish_test;
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x, input logic [31:0] m);
      cmp_count++;
      if ((g & m) !== (x & m)) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, g & m, x & m);
      end
   endtask
   // Master holds the request until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 40) begin
         cmp(0, 1, 1);
         finish_test();
      end
   endtask
   task automatic tx(input logic [7:0] v, input logic [8:0] x);
      int n;
      n = got_cnt + 1;
      apb(1'b0, ST, 32'h0);
      apb(1'b1, DT, {24'h0, v});
      for (int i = 0; i < 5000 && got_cnt < n; i++) @(posedge clk);
      if (got_cnt < n) begin
         cmp(0, 1, 1);
         finish_test();
      end
      repeat (64) @(posedge clk);
      cmp({23'h0, got}, {23'h0, x}, 32'h0000_01FF);
   endtask
   initial begin
      {resetn, psel, penable, pwrite, nine} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0;
      errors = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, ST, 32'h0); cmp(d, {24'h0, serial_pkg::STATUS_RST}, 32'hFFFF_FFFF);
      apb(1'b0, FR, 32'h0); cmp(d, {24'h0, serial_pkg::FRAME_RST}, 32'hFFFF_FFFF);
      apb(1'b0, EN, 32'h0); cmp(d, {24'h0, serial_pkg::ENABLE_RST}, 32'hFFFF_FFFF);
      apb(1'b0, 8'h14, 32'h0); cmp({31'h0, e}, 32'h1, 32'h1);
      cmp(d, 32'h0, 32'hFFFF_FFFF);
      apb(1'b1, serial_pkg::OFF_BAUD, 32'h0000_0004);
      apb(1'b1, EN, 32'h0000_000C);
      $display("test registers done");
      tx(8'hA5, 9'h0A5);
      apb(1'b1, FR, 32'h0000_0050);
      nine <= 1'b1;
      tx(8'h3C, 9'h13C);
      apb(1'b1, FR, 32'h0000_0010);
      serial_peer_inst.send(9'h1A5, 9);
      apb(1'b0, FR, 32'h0); cmp(d, 32'h80, 32'h80);
      apb(1'b0, ST, 32'h0); cmp(d, 32'h20, 32'h20);
      apb(1'b0, DT, 32'h0); cmp(d, 32'hA5, 32'hFF);
      nine <= 1'b0;
      apb(1'b1, FR, 32'h0000_0004);
      tx(8'h83, 9'h003);
      apb(1'b1, FR, 32'h0000_0006);
      tx(8'h03, 9'h083);
      $display("test frame formats done");
      apb(1'b1, FR, 32'h0);
      apb(1'b1, EN, 32'h0000_002C);
      serial_peer_inst.send(9'h011, 8);
      serial_peer_inst.send(9'h022, 8);
      apb(1'b0, ST, 32'h0); cmp(d, 32'h28, 32'h28);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      apb(1'b0, DT, 32'h0); cmp(d, 32'h11, 32'hFF);
      repeat (3) @(posedge clk);
      cmp({31'h0, irq}, 32'h0, 32'h1);
      apb(1'b1, EN, 32'h0000_008C);
      apb(1'b0, ST, 32'h0);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      apb(1'b1, EN, 32'h0000_004C);
      repeat (3) @(posedge clk);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      apb(1'b1, EN, 32'h0000_000C);
      apb(1'b1, FR, 32'h0000_0005);
      serial_peer_inst.send(9'h083, 8);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      apb(1'b0, ST, 32'h0); cmp(d, 32'h1, 32'h1);
      apb(1'b1, FR, 32'h0000_0008);
      apb(1'b1, EN, 32'h0000_000E);
      serial_peer_inst.send(9'h0B4, 8);
      apb(1'b0, EN, 32'h0); cmp(d, 32'h0, 32'h2);
      $display("test interrupts done");
      apb(1'b1, EN, 32'h0000_0009);
      repeat (192) @(posedge clk);
      cmp({31'h0, txd_o}, 32'h0, 32'h1);
      apb(1'b1, EN, 32'h0000_0008);
      $display("test break done");
      finish_test();
   end
endmodule
